//--- rtl/mawf_defines.svh
// Constants of the monitor alarm and warning flag block.
// Assumes inclusion by bare name from the package and the flag module.
`ifndef MAWF_DEFINES_SVH
`define MAWF_DEFINES_SVH

// Byte addresses on the diagnostic serial device address.
`define MAWF_DEV_ADDR        7'h51
`define MAWF_ADDR_ALARM_LOW  8'h70
`define MAWF_ADDR_ALARM_HIGH 8'h71
`define MAWF_ADDR_WARN_LOW   8'h74
`define MAWF_ADDR_WARN_HIGH  8'h75
`define MAWF_ADDR_EVT_STATUS 8'hE0
`define MAWF_ADDR_EVT_MASK   8'hE1

// Reset values.
`define MAWF_FLAGS_RESET     8'h00
`define MAWF_EVT_RESET       4'h0

// Monitored quantity indices.
`define MAWF_Q_TEMP          0
`define MAWF_Q_VOLT          1
`define MAWF_Q_BIAS          2
`define MAWF_Q_TXP           3
`define MAWF_Q_RXP           4

// Event status bits, one per flag byte.
`define MAWF_EVT_ALARM_LOW   0
`define MAWF_EVT_ALARM_HIGH  1
`define MAWF_EVT_WARN_LOW    2
`define MAWF_EVT_WARN_HIGH   3

// Reserved upper-byte bits, read as zero.
`define MAWF_RSVD_ZERO       6'h00

`endif

//--- rtl/mawf_pkg.sv
// Types shared by the monitor alarm and warning flag block.
// Assumes the defines header sits beside it on the include path.
`include "mawf_defines.svh"

package mawf_pkg;

    // One digitised monitor result or limit.
    typedef logic [15:0] mawf_word_t;

    // Upper and lower limit pair for one quantity.
    typedef struct packed {
        mawf_word_t upper;
        mawf_word_t lower;
    } mawf_limits_t;

    // The five monitored quantities, index 4 down to 0.
    typedef mawf_word_t   [4:0] mawf_meas_t;
    typedef mawf_limits_t [4:0] mawf_lim_set_t;

    // One register bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mawf_bus_t;

endpackage : mawf_pkg

//--- rtl/mawf_flags.sv
// Monitor alarm and warning flag bytes with a small event interrupt.
// Assumes a converter on core_clk that pulses conv_done with all results
// and limits valid, and a register master on the same clock.
//
// What this block does
// - Temperature alarm flags in lower alarm bits 7,6
// - Voltage alarm flags in lower alarm bits 5,4
// - Bias current alarm flags in bits 3,2
// - Transmit power alarm flags in bits 1,0
// - Receive overload and loss alarms, upper bits 7,6
// - Flag is one while condition exists
// - All flags zero until first conversion
// - Temperature warning flags in lower warning 7,6
// - Voltage warning flags in lower warning 5,4
// - Bias current warning flags in bits 3,2
// - Transmit power warning flags in bits 1,0
// - Flag bytes at addresses 112,113,116,117
// - Receive power warnings in upper warning 7,6
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "mawf_defines.svh"

module mawf_flags (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   conv_done,
    input  wire mawf_pkg::mawf_meas_t    measured,
    input  wire mawf_pkg::mawf_lim_set_t alarm_lim,
    input  wire mawf_pkg::mawf_lim_set_t warn_lim,
    input  wire mawf_pkg::mawf_bus_t     bus_req,
    output logic [7:0]                  rdata,
    output logic                        irq
);
    import mawf_pkg::*;

    // All assertions share the one clock; all but a_reset_zero are also disabled by its reset.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Comparison results per quantity, against alarm and warning limits.
    logic [4:0] over_alarm;   // Result above the alarm upper limit.
    logic [4:0] under_alarm;  // Result below the alarm lower limit.
    logic [4:0] over_warn;    // Result above the warning upper limit.
    logic [4:0] under_warn;   // Result below the warning lower limit.

    // Stored flag bytes, visible to the host.
    logic [7:0] alarm_low;    // Lower alarm byte.
    logic [7:0] alarm_high;   // Received power alarm byte.
    logic [7:0] warn_low;     // Lower warning byte.
    logic [7:0] warn_high;    // Received power warning byte.

    // Fresh flag bytes computed from the present comparisons.
    wire  [7:0] next_alarm_low;
    wire  [7:0] next_alarm_high;
    wire  [7:0] next_warn_low;
    wire  [7:0] next_warn_high;

    // Event status, mask and their update terms.
    logic [3:0] evt_status;   // Sticky: a byte gained a newly set flag.
    logic [3:0] evt_mask;     // One enables the event onto irq.
    wire  [3:0] evt_rise;     // Per byte, any flag rising this update.
    wire  [3:0] evt_clear;    // Write-one-to-clear pattern.
    wire  [3:0] next_status;  // Status after set and clear.

    // Bus decode strobes.
    wire        wr_status;
    wire        wr_mask;
    wire  [7:0] next_rdata;

    // Strict comparisons: equality with a limit is still within limits.
    genvar q;
    generate
        for (q = 0; q < 5; q++) begin : g_cmp
            assign over_alarm[q]  = measured[q] > alarm_lim[q].upper;
            assign under_alarm[q] = measured[q] < alarm_lim[q].lower;
            assign over_warn[q]   = measured[q] > warn_lim[q].upper;
            assign under_warn[q]  = measured[q] < warn_lim[q].lower;
        end
    endgenerate

    // Lower alarm byte: temperature, voltage, bias, transmit power.
    assign next_alarm_low = {
        over_alarm[`MAWF_Q_TEMP], under_alarm[`MAWF_Q_TEMP],
        over_alarm[`MAWF_Q_VOLT], under_alarm[`MAWF_Q_VOLT],
        over_alarm[`MAWF_Q_BIAS], under_alarm[`MAWF_Q_BIAS],
        over_alarm[`MAWF_Q_TXP],  under_alarm[`MAWF_Q_TXP]
    };

    // Received power alarms; the reserved low bits always read zero.
    assign next_alarm_high = {
        over_alarm[`MAWF_Q_RXP], under_alarm[`MAWF_Q_RXP],
        `MAWF_RSVD_ZERO
    };

    // Lower warning byte, same layout as the lower alarm byte.
    assign next_warn_low = {
        over_warn[`MAWF_Q_TEMP], under_warn[`MAWF_Q_TEMP],
        over_warn[`MAWF_Q_VOLT], under_warn[`MAWF_Q_VOLT],
        over_warn[`MAWF_Q_BIAS], under_warn[`MAWF_Q_BIAS],
        over_warn[`MAWF_Q_TXP],  under_warn[`MAWF_Q_TXP]
    };

    // Received power warnings with reserved low bits.
    assign next_warn_high = {
        over_warn[`MAWF_Q_RXP], under_warn[`MAWF_Q_RXP],
        `MAWF_RSVD_ZERO
    };

    // The flag bytes reload whole on every conversion, so a condition
    // that has gone clears at once; nothing latches. Host writes do
    // not reach these registers at all.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            // Power-up state shows no conditions.
            alarm_low  <= `MAWF_FLAGS_RESET;
            alarm_high <= `MAWF_FLAGS_RESET;
            warn_low   <= `MAWF_FLAGS_RESET;
            warn_high  <= `MAWF_FLAGS_RESET;
        end else if (conv_done) begin
            // A new result set replaces every flag.
            alarm_low  <= next_alarm_low;
            alarm_high <= next_alarm_high;
            warn_low   <= next_warn_low;
            warn_high  <= next_warn_high;
        end
    end

    // A byte raises an event only when a flag goes from zero to one,
    // so a condition that persists does not keep re-raising it.
    assign evt_rise[`MAWF_EVT_ALARM_LOW]  = conv_done & |(next_alarm_low & ~alarm_low);
    assign evt_rise[`MAWF_EVT_ALARM_HIGH] = conv_done & |(next_alarm_high & ~alarm_high);
    assign evt_rise[`MAWF_EVT_WARN_LOW]   = conv_done & |(next_warn_low & ~warn_low);
    assign evt_rise[`MAWF_EVT_WARN_HIGH]  = conv_done & |(next_warn_high & ~warn_high);

    // Register write decode.
    assign wr_status = bus_req.wr && (bus_req.addr == `MAWF_ADDR_EVT_STATUS);
    assign wr_mask   = bus_req.wr && (bus_req.addr == `MAWF_ADDR_EVT_MASK);
    assign evt_clear = wr_status ? bus_req.wdata[3:0] : `MAWF_EVT_RESET;

    // A rise in the same cycle as its clear survives: set wins.
    assign next_status = (evt_status & ~evt_clear) | evt_rise;

    // Status and mask registers.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            // No events pending, all masked off.
            evt_status <= `MAWF_EVT_RESET;
            evt_mask   <= `MAWF_EVT_RESET;
        end else begin
            evt_status <= next_status;
            if (wr_mask) begin
                // Only the four low bits exist.
                evt_mask <= bus_req.wdata[3:0];
            end
        end
    end

    // Read mux; unmapped addresses and flag writes read or do nothing.
    // Writes to the flag addresses fall through to no register.
    assign next_rdata =
        (bus_req.addr == `MAWF_ADDR_ALARM_LOW)  ? alarm_low  :
        (bus_req.addr == `MAWF_ADDR_ALARM_HIGH) ? alarm_high :
        (bus_req.addr == `MAWF_ADDR_WARN_LOW)   ? warn_low   :
        (bus_req.addr == `MAWF_ADDR_WARN_HIGH)  ? warn_high  :
        (bus_req.addr == `MAWF_ADDR_EVT_STATUS) ? {4'h0, evt_status} :
        (bus_req.addr == `MAWF_ADDR_EVT_MASK)   ? {4'h0, evt_mask}   :
        `MAWF_FLAGS_RESET;

    // Read data stands only in the cycle after the strobe; zero
    // otherwise so a stale byte is never mistaken for an answer.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata <= `MAWF_FLAGS_RESET;
        end else if (bus_req.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= `MAWF_FLAGS_RESET;
        end
    end

    // Interrupt taken from the next status so it lines up with it;
    // registered so the output has no glitches.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & (wr_mask ? bus_req.wdata[3:0] : evt_mask));
        end
    end

    // Step sequences for a conversion and for a flag read.
    sequence s_conv;
        conv_done;
    endsequence

    sequence s_read(logic [7:0] a);
        bus_req.rd && bus_req.addr == a;
    endsequence

    // A register write strobe aimed at one address.
    sequence s_write(logic [7:0] a);
        bus_req.wr && bus_req.addr == a;
    endsequence

    // Reset leaves every flag byte at zero on the following edge.
    a_reset_zero: assert property (@(posedge core_clk) disable iff (1'b0)
        sys_rst |=> (alarm_low | alarm_high | warn_low | warn_high) == 8'h00)
        else $error("flag bytes not zero after reset");

    // Flags only move on a conversion, never on a host write.
    a_flags_hold: assert property (!conv_done |=>
        $stable({alarm_low, alarm_high, warn_low, warn_high}))
        else $error("flags changed without a conversion");

    // Temperature alarm pair follows the comparison.
    a_temp_alarm: assert property (s_conv |=>
        alarm_low[7:6] == $past({measured[0] > alarm_lim[0].upper,
                                 measured[0] < alarm_lim[0].lower}))
        else $error("temperature alarm flags wrong");

    // Voltage alarm pair follows the comparison.
    a_volt_alarm: assert property (s_conv |=>
        alarm_low[5:4] == $past({measured[1] > alarm_lim[1].upper,
                                 measured[1] < alarm_lim[1].lower}))
        else $error("voltage alarm flags wrong");

    // Bias current alarm pair follows the comparison.
    a_bias_alarm: assert property (s_conv |=>
        alarm_low[3:2] == $past({measured[2] > alarm_lim[2].upper,
                                 measured[2] < alarm_lim[2].lower}))
        else $error("bias alarm flags wrong");

    // Transmit power alarm pair follows the comparison.
    a_txp_alarm: assert property (s_conv |=>
        alarm_low[1:0] == $past({measured[3] > alarm_lim[3].upper,
                                 measured[3] < alarm_lim[3].lower}))
        else $error("transmit power alarm flags wrong");

    // Received power alarms, reserved bits zero.
    a_rxp_alarm: assert property (s_conv |=>
        alarm_high == $past({measured[4] > alarm_lim[4].upper,
                             measured[4] < alarm_lim[4].lower, 6'h00}))
        else $error("receive power alarm byte wrong");

    // Lower warning byte matches all eight comparisons.
    a_warn_low: assert property (s_conv |=>
        warn_low == $past({over_warn[0], under_warn[0], over_warn[1],
                           under_warn[1], over_warn[2], under_warn[2],
                           over_warn[3], under_warn[3]}))
        else $error("lower warning byte wrong");

    // Received power warnings, reserved bits zero.
    a_warn_high: assert property (s_conv |=>
        warn_high == $past({measured[4] > warn_lim[4].upper,
                            measured[4] < warn_lim[4].lower, 6'h00}))
        else $error("upper warning byte wrong");

    // Reading the received power alarm byte returns it one cycle later.
    a_read_alarm: assert property (s_read(`MAWF_ADDR_ALARM_HIGH) |=>
        rdata == $past(alarm_high))
        else $error("alarm byte read wrong");

    // Reading the lower warning byte returns it one cycle later.
    a_read_warn: assert property (s_read(`MAWF_ADDR_WARN_LOW) |=>
        rdata == $past(warn_low))
        else $error("warning byte read wrong");

    // A conversion with no limit crossed leaves all flags clear.
    a_clear_ok: assert property (s_conv ##0
        (over_alarm | under_alarm | over_warn | under_warn) == 5'h00 |=>
        (alarm_low | alarm_high | warn_low | warn_high) == 8'h00)
        else $error("flag stuck with quantity in limits");

    // Reading the lower alarm byte returns it one cycle later.
    a_read_alow: assert property (s_read(`MAWF_ADDR_ALARM_LOW) |=>
        rdata == $past(alarm_low))
        else $error("lower alarm byte read wrong");

    // Reading the upper warning byte returns it one cycle later.
    a_read_whigh: assert property (s_read(`MAWF_ADDR_WARN_HIGH) |=>
        rdata == $past(warn_high))
        else $error("upper warning byte read wrong");

    // With no read strobe the read port shows zero next cycle.
    a_read_idle: assert property (!bus_req.rd |=>
        rdata == `MAWF_FLAGS_RESET)
        else $error("read data stands without a read");

    // Reserved low bits of both received power bytes stay zero.
    a_rsvd_zero: assert property (
        alarm_high[5:0] == `MAWF_RSVD_ZERO && warn_high[5:0] == `MAWF_RSVD_ZERO)
        else $error("reserved flag bits not zero");

    // The interrupt level matches the registered status under its mask.
    a_irq_level: assert property (
        irq == |(evt_status & evt_mask))
        else $error("interrupt level disagrees with status and mask");

    // A pending status bit survives unless written with a one.
    a_status_sticky: assert property (1'b1 |=>
        ($past(evt_status & ~evt_clear) & ~evt_status) == `MAWF_EVT_RESET)
        else $error("status bit lost without a clear");

    // A newly set lower alarm flag raises its status bit.
    a_rise_sets: assert property (
        s_conv ##0 |(next_alarm_low & ~alarm_low) |=>
        evt_status[`MAWF_EVT_ALARM_LOW])
        else $error("alarm rise did not set status");

    // A mask write lands on the next edge.
    a_mask_write: assert property (s_write(`MAWF_ADDR_EVT_MASK) |=>
        evt_mask == $past(bus_req.wdata[3:0]))
        else $error("mask write did not land");

    // A lower alarm address write alone never moves the lower alarm byte.
    a_write_none: assert property (
        s_write(`MAWF_ADDR_ALARM_LOW) ##0 !conv_done |=>
        $stable(alarm_low))
        else $error("host write changed a flag byte");

endmodule : mawf_flags

//--- verif/mawf_host_model.sv
// Host side of the flag block register port, one byte per request.
// Assumes core_clk is shared with the flag block and reads return one cycle later.
`timescale 1ns/10ps
`include "mawf_defines.svh"

module mawf_host_model (
    input  wire logic          core_clk,
    input  wire logic [7:0]    rdata,
    output mawf_pkg::mawf_bus_t bus_req
);
    import mawf_pkg::*;

    // The bus is idle from time zero.
    initial bus_req = '0;

    // One write cycle; reserved bits of the upper alarm byte always go out as zero.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req.addr  <= a;
        bus_req.wdata <= (a == `MAWF_ADDR_ALARM_HIGH) ? (d & 8'hC0) : d;
        bus_req.wr    <= 1'b1;
        @(posedge core_clk);
        bus_req.wr    <= 1'b0;
        bus_req.addr  <= ~a; // A released address must not look still valid.
    endtask : wr

    // One read cycle; the byte is taken while it stands, after the strobe edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge core_clk);
        bus_req.rd   <= 1'b0;
        bus_req.addr <= ~a;
        #1 d = rdata;
    endtask : rd
endmodule : mawf_host_model

//--- verif/mawf_flags_test.sv
// Self-checking bench of the alarm and warning flag block.
// Assumes the host model drives the register port and the bench drives the converter side.
`timescale 1ns/10ps
`include "mawf_defines.svh"

module mawf_flags_test;
    import mawf_pkg::*;

    logic          core_clk;
    logic          sys_rst;
    logic          conv_done;
    logic          irq;
    logic [7:0]    rdata;
    mawf_meas_t    measured;
    mawf_lim_set_t alarm_lim;
    mawf_lim_set_t warn_lim;
    mawf_bus_t     bus_req;
    int            n_errors = 0;
    int            checks_done = 0;
    logic [15:0]   vals [9] = '{16'h00C9, 16'h00C8, 16'h0097, 16'h0096, 16'h0064,
                                16'h0050, 16'h004F, 16'h0032, 16'h0031};

    mawf_flags i_mawf_flags (.core_clk(core_clk), .sys_rst(sys_rst), .conv_done(conv_done),
        .measured(measured), .alarm_lim(alarm_lim), .warn_lim(warn_lim),
        .bus_req(bus_req), .rdata(rdata), .irq(irq));
    mawf_host_model i_mawf_host_model (.core_clk(core_clk), .rdata(rdata), .bus_req(bus_req));

    // Free-running 20 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, want);
        end
    endtask : check

    // Reads one byte through the host and compares it.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
        logic [7:0] d;
        i_mawf_host_model.rd(a, d);
        check(d, want);
    endtask : rdchk

    // Presents a new result for one quantity with a one-cycle completion pulse.
    task automatic conv(input int q, input logic [15:0] v);
        @(posedge core_clk);
        measured[q] <= v;
        conv_done   <= 1'b1;
        @(posedge core_clk);
        conv_done   <= 1'b0;
    endtask : conv

    // Expected flag bytes {0x75, 0x74, 0x71, 0x70}; strict comparisons on both sides.
    function automatic logic [31:0] exp_flags();
        logic [31:0] e;
        e = '0;
        for (int q = 0; q < 4; q++) begin
            e[7-2*q]  = measured[q] > alarm_lim[q].upper;
            e[6-2*q]  = measured[q] < alarm_lim[q].lower;
            e[23-2*q] = measured[q] > warn_lim[q].upper;
            e[22-2*q] = measured[q] < warn_lim[q].lower;
        end
        e[15] = measured[4] > alarm_lim[4].upper;
        e[14] = measured[4] < alarm_lim[4].lower;
        e[31] = measured[4] > warn_lim[4].upper;
        e[30] = measured[4] < warn_lim[4].lower;
        return e;
    endfunction : exp_flags

    // Reads all four flag bytes against the current results and limits.
    task automatic check_flags();
        logic [31:0] e;
        e = exp_flags();
        rdchk(`MAWF_ADDR_ALARM_LOW, e[7:0]);
        rdchk(`MAWF_ADDR_ALARM_HIGH, e[15:8]);
        rdchk(`MAWF_ADDR_WARN_LOW, e[23:16]);
        rdchk(`MAWF_ADDR_WARN_HIGH, e[31:24]);
    endtask : check_flags

    // Every flag register and the event registers read zero; so does a hole.
    task automatic t_zero();
        rdchk(`MAWF_ADDR_ALARM_LOW, 8'h00);
        rdchk(`MAWF_ADDR_ALARM_HIGH, 8'h00);
        rdchk(`MAWF_ADDR_WARN_LOW, 8'h00);
        rdchk(`MAWF_ADDR_WARN_HIGH, 8'h00);
        rdchk(`MAWF_ADDR_EVT_STATUS, 8'h00);
        rdchk(`MAWF_ADDR_EVT_MASK, 8'h00);
        rdchk(8'h33, 8'h00);
    endtask : t_zero

    // Each quantity walks across both limit pairs, equal values included, and back.
    task automatic t_sweep();
        for (int q = 0; q < 5; q++) begin
            foreach (vals[i]) begin
                conv(q, vals[i]);
                check_flags();
            end
            conv(q, 16'h0064);
        end
        check_flags();
    endtask : t_sweep

    // Host writes to the flag bytes leave them as the converter set them.
    task automatic t_writes();
        conv(0, 16'h00C9);
        conv(4, 16'h0031);
        i_mawf_host_model.wr(`MAWF_ADDR_ALARM_LOW, 8'h00);
        i_mawf_host_model.wr(`MAWF_ADDR_ALARM_HIGH, 8'hFF);
        i_mawf_host_model.wr(`MAWF_ADDR_WARN_LOW, 8'h00);
        i_mawf_host_model.wr(`MAWF_ADDR_WARN_HIGH, 8'hFF);
        check_flags();
    endtask : t_writes

    // Event status, mask and the level interrupt; read data stands one cycle only.
    task automatic t_irq();
        conv(0, 16'h0064);
        conv(4, 16'h0064);
        i_mawf_host_model.wr(`MAWF_ADDR_EVT_STATUS, 8'h0F);
        i_mawf_host_model.wr(`MAWF_ADDR_EVT_MASK, 8'h01);
        rdchk(`MAWF_ADDR_EVT_MASK, 8'h01);
        conv(0, 16'h00C9);
        repeat (2) @(posedge core_clk);
        #1 check({7'h00, irq}, 8'h01);
        rdchk(`MAWF_ADDR_EVT_STATUS, 8'h05);
        @(posedge core_clk);
        #1 check(rdata, 8'h00);
        i_mawf_host_model.wr(`MAWF_ADDR_EVT_STATUS, 8'h05);
        repeat (2) @(posedge core_clk);
        #1 check({7'h00, irq}, 8'h00);
        i_mawf_host_model.wr(`MAWF_ADDR_EVT_MASK, 8'h00);
        conv(0, 16'h0064);
        conv(0, 16'h00C9);
        repeat (2) @(posedge core_clk);
        #1 check({7'h00, irq}, 8'h00);
        rdchk(`MAWF_ADDR_EVT_STATUS, 8'h05);
    endtask : t_irq

    // A second reset with flags set brings every byte back to zero.
    task automatic t_rereset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_zero();
    endtask : t_rereset

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // Limits stay fixed: alarm 200/50, warning 150/80, every result starts at 100.
    initial begin
        sys_rst   = 1'b1;
        conv_done = 1'b0;
        for (int q = 0; q < 5; q++) begin
            measured[q]        = 16'h0064;
            alarm_lim[q].upper = 16'h00C8;
            alarm_lim[q].lower = 16'h0032;
            warn_lim[q].upper  = 16'h0096;
            warn_lim[q].lower  = 16'h0050;
        end
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_zero();
        t_sweep();
        t_writes();
        t_irq();
        t_rereset();
        give_verdict();
    end

    // The tests need a few hundred cycles; this cuts a hang short well beyond that.
    initial begin
        #1000000;
        n_errors++;
        give_verdict();
    end
endmodule : mawf_flags_test
